// file: core/fcsp_core.sv
/*
 * Filter control serial port: four-wire serial slave, indirect register
 * file, calibration sequencer, fuse programming and soft reset.
 * Assumes the serial pins are asynchronous to I_CLK and that the serial
 * clock is well below a quarter of I_CLK; the calibration result comes
 * from the analog measurement on I_CAL_RESULT.
 */
`timescale 1ns/1ns
// Function
// - writing zero to register 04h starts a calibration cycle.
// - busy bit in status stays high while calibration runs.
// - result shown in status 3:0 and copied into fine bandwidth register.
// - host may override fine bandwidth; written value is then used.
// - status bit 5 shows active write pulse; host waits for zero.
// - programming sets a fuse bit to one permanently; here fuse_ff survives soft reset but I_ARST_N clears it.
// - a write to register 0Dh launches a fuse write pulse when 0Bh bit 0 is set and no pulse is active.
// - fuse settings apply only when fuse-use bit 13 is programmed.
// - writing one then zero to register 00h bit 5 gives soft reset.
// - registers return to defaults about 250 us after power up.
// - frame carries 3-bit chip select; device answers only to 101.
// - each cycle returns register addressed by pointer before the cycle.
// - write data commits only when the enable line returns high.
// - device samples input data on rising serial clock edges.
// - a frame is 32 serial clocks with enable low, MSB first.
// - frame is 24 data, 5 address, 3 chip select bits.
// - output released when not addressed; driven after being addressed.
// - frame with foreign chip select changes no register.
module fcsp_core #(
    parameter int POR_CYCLES = fcsp_pkg::POR_CYC
) (
    input  wire logic              I_CLK,
    input  wire logic              I_ARST_N,
    input  wire fcsp_pkg::serial_in_t I_SER,
    input  wire logic [3:0]        I_CAL_RESULT,
    output logic                   O_SERIAL_DATA_OUT,
    output logic                   O_SERIAL_DATA_OUT_OE,
    output logic [3:0]             O_FINE_BW,
    output logic                   O_CLK_DOUBLER,
    output logic                   O_CAL_ENABLE,
    output logic                   O_FUSE_PULSE,
    output logic                   O_READY
);
    import fcsp_pkg::*;

    // reset release through two flops
    logic        rst_s1_ff;
    logic        rst_n;
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_s1_ff <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n     <= rst_s1_ff;
        end
    end

    // two-flop synchronisers for pins; first stage read only by second
    serial_in_t  sync1_ff;
    serial_in_t  sync2_ff;
    logic        sck_d_ff;
    logic        sen_d_ff;
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= '{sen_n: 1'b1, sck: 1'b0, serial_data_in: 1'b0};
            sync2_ff <= '{sen_n: 1'b1, sck: 1'b0, serial_data_in: 1'b0};
            sck_d_ff <= 1'b0;
            sen_d_ff <= 1'b1;
        end else begin
            sync1_ff <= I_SER;
            sync2_ff <= sync1_ff;
            sck_d_ff <= sync2_ff.sck;
            sen_d_ff <= sync2_ff.sen_n;
        end
    end

    logic sck_rise;
    logic sen_rise;
    assign sck_rise = sync2_ff.sck & ~sck_d_ff & ~sync2_ff.sen_n;
    assign sen_rise = sync2_ff.sen_n & ~sen_d_ff;

    // analog result is asynchronous; resample before the sequencer
    logic [3:0]  cres_s1_ff;
    logic [3:0]  cres_s2_ff;
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cres_s1_ff <= 4'h0;
            cres_s2_ff <= 4'h0;
        end else begin
            cres_s1_ff <= I_CAL_RESULT;
            cres_s2_ff <= cres_s1_ff;
        end
    end

    // register state
    logic [23:0] ptr_ff,     nxt_ptr;
    logic [23:0] calctl_ff,  nxt_calctl;
    logic [3:0]  finebw_ff,  nxt_finebw;
    logic [23:0] calper_ff,  nxt_calper;
    logic [23:0] measadj_ff, nxt_measadj;
    logic        fwen_ff,    nxt_fwen;
    logic [3:0]  fidx_ff,    nxt_fidx;
    logic [15:0] fuse_ff,    nxt_fuse;
    logic [3:0]  calres_ff,  nxt_calres;
    cal_state_t  cal_ff,     nxt_cal;
    logic [6:0]  calcnt_ff,  nxt_calcnt;
    logic [4:0]  fcnt_ff,    nxt_fcnt;
    logic        srst_ff,    nxt_srst;
    logic [31:0] shin_ff,    nxt_shin;
    logic [31:0] shout_ff,   nxt_shout;
    logic [5:0]  bitcnt_ff,  nxt_bitcnt;
    logic        addr_ff,    nxt_addr;
    logic [23:0] porcnt_ff,  nxt_porcnt;
    logic        ready_ff,   nxt_ready;

    frame_t      frm;
    logic        commit;
    logic        soft_rst;
    logic [23:0] rd_word;
    logic [23:0] status;
    assign frm    = shin_ff;
    // frame counted complete only at exactly 32 bits and our own code
    assign commit = sen_rise && bitcnt_ff == 6'(FRAME_BITS)
                    && frm.csel == OWN_CSEL && ready_ff;

    // soft reset: bit 5 was one, now written zero
    assign soft_rst = commit && frm.addr == REG_PTR && srst_ff
                      && !frm.data[PTR_SRST_BIT];

    assign status = {18'h0, (fcnt_ff != 5'h0),
                     (cal_ff == CAL_RUN), calres_ff};

    // read mux, addressed by pointer as it stands
    always_comb begin
        case (ptr_ff[4:0])
            REG_PTR:     rd_word = ptr_ff;
            REG_CALCTL:  rd_word = calctl_ff;
            REG_FINEBW:  rd_word = {20'h0, finebw_ff};
            REG_CALPER:  rd_word = calper_ff;
            REG_MEASADJ: rd_word = measadj_ff;
            REG_STATUS:  rd_word = status;
            REG_FUSEVAL: rd_word = {8'h0, fuse_ff};
            REG_FUSEWEN: rd_word = {23'h0, fwen_ff};
            REG_FUSEIDX: rd_word = {20'h0, fidx_ff};
            default:     rd_word = RST_WORD;
        endcase
    end

    // serial shifter next state
    always_comb begin
        nxt_shin   = shin_ff;
        nxt_shout  = shout_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_addr   = addr_ff;
        if (sync2_ff.sen_n) begin
            nxt_bitcnt = 6'h00;
            // preload answer; pointer is still the pre-cycle value
            nxt_shout  = {rd_word, ptr_ff[4:0], OWN_CSEL};
        end else if (sck_rise) begin
            nxt_shin  = {shin_ff[30:0], sync2_ff.serial_data_in};
            if (bitcnt_ff != 6'h00)
                nxt_shout = {shout_ff[30:0], 1'b0};
            if (bitcnt_ff != 6'h3F)
                nxt_bitcnt = bitcnt_ff + 6'h01;
        end
        // addressed state: driven from a good frame until a foreign one;
        // frames ahead of the power-up settle must not claim the line
        if (sen_rise && bitcnt_ff == 6'(FRAME_BITS) && ready_ff)
            nxt_addr = frm.csel == OWN_CSEL;
    end

    // register file, calibration and fuse next state
    always_comb begin
        nxt_ptr     = ptr_ff;
        nxt_calctl  = calctl_ff;
        nxt_finebw  = finebw_ff;
        nxt_calper  = calper_ff;
        nxt_measadj = measadj_ff;
        nxt_fwen    = fwen_ff;
        nxt_fidx    = fidx_ff;
        nxt_fuse    = fuse_ff;
        nxt_calres  = calres_ff;
        nxt_cal     = cal_ff;
        nxt_calcnt  = calcnt_ff;
        nxt_fcnt    = fcnt_ff;
        nxt_srst    = srst_ff;
        nxt_porcnt  = porcnt_ff;
        nxt_ready   = ready_ff;
        // power-up settle before registers answer
        if (!ready_ff) begin
            if (porcnt_ff == 24'(POR_CYCLES - 1))
                nxt_ready = 1'b1;
            else
                nxt_porcnt = porcnt_ff + 24'h1;
        end
        if (commit) begin
            case (frm.addr)
                REG_PTR: begin
                    nxt_ptr  = frm.data;
                    nxt_srst = frm.data[PTR_SRST_BIT];
                end
                REG_CALCTL:  nxt_calctl  = frm.data;
                REG_FINEBW:  nxt_finebw  = frm.data[3:0];
                REG_CALPER:  nxt_calper  = frm.data;
                REG_MEASADJ: nxt_measadj = frm.data;
                REG_FUSEWEN: nxt_fwen    = frm.data[FUSE_WEN_BIT];
                REG_FUSEIDX: nxt_fidx    = frm.data[3:0];
                REG_CALSTB: begin
                    if (frm.data == RST_WORD && cal_ff != CAL_RUN) begin
                        nxt_cal    = CAL_RUN;
                        nxt_calcnt = 7'h00;
                    end
                end
                REG_FUSESTB: begin
                    if (fwen_ff && fcnt_ff == 5'h0) begin
                        nxt_fcnt = 5'(FUSE_CYC);
                        nxt_fuse = fuse_ff | (16'h1 << fidx_ff);
                    end
                end
                default: ;
            endcase
        end
        // fuse write pulse duration
        if (fcnt_ff != 5'h0)
            nxt_fcnt = fcnt_ff - 5'h1;
        // calibration sequencer
        case (cal_ff)
            CAL_IDLE: ;
            CAL_RUN: begin
                if (calcnt_ff == 7'(CAL_CYC - 1)) begin
                    nxt_cal    = CAL_DONE;
                    nxt_calres = cres_s2_ff;
                end else begin
                    nxt_calcnt = calcnt_ff + 7'h01;
                end
            end
            CAL_DONE: begin
                nxt_finebw = calres_ff;
                nxt_cal    = CAL_IDLE;
            end
            default: nxt_cal = CAL_IDLE;
        endcase
    end

    // soft reset clears all but fuses, power-up counter and serial port
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fuse_ff    <= 16'h0000;
            fcnt_ff    <= 5'h00;
            porcnt_ff  <= 24'h000000;
            ready_ff   <= 1'b0;
            shin_ff    <= 32'h00000000;
            shout_ff   <= 32'h00000000;
            bitcnt_ff  <= 6'h00;
            addr_ff    <= 1'b0;
        end else begin
            fuse_ff    <= nxt_fuse;
            fcnt_ff    <= nxt_fcnt;
            porcnt_ff  <= nxt_porcnt;
            ready_ff   <= nxt_ready;
            shin_ff    <= nxt_shin;
            shout_ff   <= nxt_shout;
            bitcnt_ff  <= nxt_bitcnt;
            addr_ff    <= nxt_addr;
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ptr_ff     <= RST_WORD;
            calctl_ff  <= RST_WORD;
            finebw_ff  <= 4'h0;
            calper_ff  <= RST_WORD;
            measadj_ff <= RST_WORD;
            fwen_ff    <= 1'b0;
            fidx_ff    <= 4'h0;
            calres_ff  <= 4'h0;
            cal_ff     <= CAL_IDLE;
            calcnt_ff  <= 7'h00;
            srst_ff    <= 1'b0;
        end else if (soft_rst) begin
            ptr_ff     <= RST_WORD;
            calctl_ff  <= RST_WORD;
            finebw_ff  <= 4'h0;
            calper_ff  <= RST_WORD;
            measadj_ff <= RST_WORD;
            fwen_ff    <= 1'b0;
            fidx_ff    <= 4'h0;
            calres_ff  <= 4'h0;
            cal_ff     <= CAL_IDLE;
            calcnt_ff  <= 7'h00;
            srst_ff    <= 1'b0;
        end else begin
            ptr_ff     <= nxt_ptr;
            calctl_ff  <= nxt_calctl;
            finebw_ff  <= nxt_finebw;
            calper_ff  <= nxt_calper;
            measadj_ff <= nxt_measadj;
            fwen_ff    <= nxt_fwen;
            fidx_ff    <= nxt_fidx;
            calres_ff  <= nxt_calres;
            cal_ff     <= nxt_cal;
            calcnt_ff  <= nxt_calcnt;
            srst_ff    <= nxt_srst;
        end
    end

    // outputs, all registered
    logic [3:0]  bw_sel;
    // stored fine code takes over only once the use flag is burnt
    assign bw_sel = fuse_ff[FUSE_USE_BIT] ? fuse_ff[3:0] : finebw_ff;
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_SERIAL_DATA_OUT    <= 1'b0;
            O_SERIAL_DATA_OUT_OE <= 1'b0;
            O_FINE_BW            <= 4'h0;
            O_CLK_DOUBLER        <= 1'b0;
            O_CAL_ENABLE         <= 1'b0;
            O_FUSE_PULSE         <= 1'b0;
            O_READY              <= 1'b0;
        end else begin
            O_SERIAL_DATA_OUT    <= shout_ff[31];
            O_SERIAL_DATA_OUT_OE <= addr_ff && !sync2_ff.sen_n
                                    ? 1'b1 : addr_ff;
            O_FINE_BW            <= bw_sel;
            O_CLK_DOUBLER        <= calctl_ff[CAL_DBL_BIT];
            O_CAL_ENABLE         <= calctl_ff[CAL_EN_BIT];
            O_FUSE_PULSE         <= fcnt_ff != 5'h0;
            O_READY              <= ready_ff;
        end
    end

endmodule : fcsp_core

// file: core/fcsp_pkg.sv
/*
 * Package for the filter control serial port: register indices, field
 * positions, reset values, frame layout and timing counts.
 * Assumes a 20 MHz system clock sampling the serial pins.
 */
package fcsp_pkg;

    localparam int          CLK_HZ        = 20_000_000;
    localparam int          FRAME_BITS    = 32;
    localparam int          DATA_BITS     = 24;
    localparam int          ADDR_BITS     = 5;
    localparam int          CSEL_BITS     = 3;
    localparam logic [2:0]  OWN_CSEL      = 3'h5;

    // register indices
    localparam logic [4:0]  REG_PTR       = 5'h00;
    localparam logic [4:0]  REG_CALCTL    = 5'h01;
    localparam logic [4:0]  REG_FINEBW    = 5'h03;
    localparam logic [4:0]  REG_CALSTB    = 5'h04;
    localparam logic [4:0]  REG_CALPER    = 5'h05;
    localparam logic [4:0]  REG_MEASADJ   = 5'h06;
    localparam logic [4:0]  REG_STATUS    = 5'h08;
    localparam logic [4:0]  REG_FUSEWEN   = 5'h0B;
    localparam logic [4:0]  REG_FUSEIDX   = 5'h0C;
    localparam logic [4:0]  REG_FUSESTB   = 5'h0D;
    localparam logic [4:0]  REG_FUSEVAL   = 5'h0A;

    // field positions
    localparam int          PTR_SRST_BIT  = 5;
    localparam int          CAL_EN_BIT    = 1;
    localparam int          CAL_DBL_BIT   = 5;
    localparam int          ST_BUSY_BIT   = 4;
    localparam int          ST_FUSE_BIT   = 5;
    localparam int          FUSE_USE_BIT  = 13;
    localparam int          FUSE_WEN_BIT  = 0;

    // reset values
    localparam logic [23:0] RST_WORD      = 24'h000000;

    // timing
    localparam int          POR_US        = 250;
    localparam int          POR_CYC       = POR_US * (CLK_HZ / 1_000_000);
    localparam int          CAL_CYC       = 64;
    localparam int          FUSE_CYC      = 16;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01,
        CAL_DONE = 2'b11
    } cal_state_t;

    typedef struct packed {
        logic       sen_n;
        logic       sck;
        logic       serial_data_in;
    } serial_in_t;

    typedef struct packed {
        logic [23:0] data;
        logic [4:0]  addr;
        logic [2:0]  csel;
    } frame_t;

endpackage : fcsp_pkg

// file: sim/fcsp_core_assertions.sv
/* port checks for fcsp_core, bound to each instance.
   assumes one clock domain and the instance's power-up count */
`timescale 1ns/1ns
module fcsp_core_assertions #(
    parameter int POR_CYCLES = fcsp_pkg::POR_CYC
) (
    input wire logic                 I_CLK,
    input wire logic                 I_ARST_N,
    input wire fcsp_pkg::serial_in_t I_SER,
    input wire logic [3:0]           I_CAL_RESULT,
    input wire logic                 O_SERIAL_DATA_OUT,
    input wire logic                 O_SERIAL_DATA_OUT_OE,
    input wire logic [3:0]           O_FINE_BW,
    input wire logic                 O_CLK_DOUBLER,
    input wire logic                 O_CAL_ENABLE,
    input wire logic                 O_FUSE_PULSE,
    input wire logic                 O_READY
);
    import fcsp_pkg::*;
    logic [15:0] up_ff, nxt_up;
    logic [4:0]  pul_ff, nxt_pul;

    // age since reset saturates so long runs never wrap
    always_comb begin
        nxt_up  = (&up_ff) ? up_ff : up_ff + 16'h1;
        nxt_pul = O_FUSE_PULSE ? pul_ff + 5'h1 : 5'h0;
    end
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            up_ff  <= 16'h0;
            pul_ff <= 5'h0;
        end else begin
            up_ff  <= nxt_up;
            pul_ff <= nxt_pul;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);

    a_ready_early: assert property (
        int'(up_ff) < POR_CYCLES |-> !O_READY) else $error("ready early");
    a_ready_late: assert property (
        int'(up_ff) > POR_CYCLES + 6 |-> O_READY) else $error("ready late");
    a_quiet_before_ready: assert property (
        !O_READY |-> {O_FINE_BW, O_CLK_DOUBLER, O_CAL_ENABLE, O_FUSE_PULSE,
        O_SERIAL_DATA_OUT_OE} == 8'h00) else $error("output before ready");
    a_oe_frame_end: assert property (
        $changed(O_SERIAL_DATA_OUT_OE) |-> I_SER.sen_n)
        else $error("output enable moved mid frame");
    a_cfg_frame_end: assert property (
        $changed(O_CAL_ENABLE) || $changed(O_CLK_DOUBLER)
        |-> I_SER.sen_n && $past(I_SER.sen_n, 2))
        else $error("config moved mid frame");
    a_pulse_frame_end: assert property (
        $rose(O_FUSE_PULSE) |-> I_SER.sen_n) else $error("pulse mid frame");
    a_pulse_length: assert property (
        $fell(O_FUSE_PULSE) |-> pul_ff == 5'h10) else $error("pulse length");
    a_pulse_bound: assert property (
        O_FUSE_PULSE |-> pul_ff < 5'h10) else $error("pulse too long");
    a_sdo_settled: assert property (
        (!I_SER.sen_n && !I_SER.sck) [*6] |-> $stable(O_SERIAL_DATA_OUT))
        else $error("serial out moved while clock low");
endmodule : fcsp_core_assertions

bind fcsp_core fcsp_core_assertions #(.POR_CYCLES(POR_CYCLES)) u_chk (.*);

// file: sim/fcsp_host.sv
/* host model driving the serial pins of the filter control port.
   assumes the bench clock and the device's serial output line */
`timescale 1ns/1ns
module fcsp_host (
    input  wire logic           i_clk,
    input  wire logic           i_sdo,
    output fcsp_pkg::serial_in_t o_ser
);
    import fcsp_pkg::*;

    // enable high, serial clock parked low between frames
    initial o_ser = 3'b100;

    task automatic hw(input int n);
        repeat (n) @(negedge i_clk);
    endtask : hw

    // n bits of f, msb first; reply caught late in the low phase,
    // well after the device moves its output on the rising edge
    task automatic xfer(input frame_t f, input int n,
                        output logic [31:0] r);
        r = 32'h0;
        for (int i = 0; i < n; i++) begin
            o_ser.sen_n = 1'b0;
            o_ser.serial_data_in   = f[31-i];
            hw(4);
            o_ser.sck = 1'b1;
            hw(4);
            o_ser.sck = 1'b0;
            hw(4);
            r[31-i] = i_sdo;
        end
        o_ser.sen_n = 1'b1;
        o_ser.serial_data_in   = ~o_ser.serial_data_in;       // released line shows no stale bit
        hw(12);
    endtask : xfer
endmodule : fcsp_host

// file: sim/tb_filter_control_serial_port.sv
/* self-checking bench for fcsp_core with a host model on the pins.
   assumes a shortened power-up count so the run stays brief */
`timescale 1ns/1ns
module tb_filter_control_serial_port;
    import fcsp_pkg::*;
    typedef struct packed {
        logic [4:0]  a;
        logic [23:0] w;
        logic [23:0] r;
    } row_t;
    logic        clk;
    logic        arst_n;
    logic [3:0]  cal_res;
    serial_in_t  ser;
    logic        serial_data_out, oe, dbl, cal_en, fpulse, ready;
    logic [3:0]  fine;
    logic [31:0] rep;
    int          err_total;
    int          comparisons;
    row_t        rows [8];

    fcsp_core #(.POR_CYCLES(8)) dut (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_SER(ser),
        .I_CAL_RESULT(cal_res), .O_SERIAL_DATA_OUT(serial_data_out),
        .O_SERIAL_DATA_OUT_OE(oe), .O_FINE_BW(fine),
        .O_CLK_DOUBLER(dbl), .O_CAL_ENABLE(cal_en),
        .O_FUSE_PULSE(fpulse), .O_READY(ready));
    fcsp_host u_host (.i_clk(clk), .i_sdo(serial_data_out), .o_ser(ser));

    task automatic results;
        if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    task automatic cmp_word(input logic [31:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t %s got %b want %b", $time, m, got, exp);
        end
    endtask : cmp_bit

    task automatic wr(input logic [4:0] a, input logic [23:0] d,
                      input logic [2:0] cs = OWN_CSEL, input int n = 32);
        u_host.xfer({d, a, cs}, n, rep);
    endtask : wr

    // point at a, then point again and catch the reply
    task automatic rd(input logic [4:0] a, input logic [23:0] e);
        wr(REG_PTR, {19'h0, a});
        wr(REG_PTR, {19'h0, a});
        cmp_word(rep, {e, a, OWN_CSEL}, "read back");
    endtask : rd

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard, far beyond the roughly one millisecond needed
    initial begin
        #3_000_000;
        err_total++;
        results();
    end

    initial begin
        arst_n  = 1'b0;
        cal_res = 4'hA;
        rows[0] = {REG_CALCTL, 24'h000022, 24'h000022};
        rows[1] = {REG_CALPER, 24'h004E20, 24'h004E20};
        rows[2] = {REG_MEASADJ, 24'h000096, 24'h000096};
        rows[3] = {REG_FUSEIDX, 24'h00000D, 24'h00000D};
        rows[4] = {REG_CALSTB, 24'h000001, 24'h000000};
        rows[5] = {REG_STATUS, 24'hFFFFFF, 24'h000000};
        rows[6] = {5'h1F, 24'h00ABCD, 24'h000000};
        rows[7] = {REG_FINEBW, 24'h000007, 24'h000007};
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        cmp_word({23'h0, fine, dbl, cal_en, fpulse, oe, ready}, 32'h0,
                 "reset outputs");
        repeat (40) if (ready !== 1'b1) @(negedge clk);
        cmp_bit(ready, 1'b1, "ready");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r);
        end
        cmp_bit(dbl, 1'b1, "doubler");
        cmp_bit(cal_en, 1'b1, "cal enable");
        cmp_word({28'h0, fine}, 32'h7, "fine code");
        // foreign chip code, then a frame one bit short
        wr(REG_CALCTL, 24'h0, 3'h4);
        cmp_bit(cal_en, 1'b1, "foreign frame");
        cmp_bit(oe, 1'b0, "released");
        wr(REG_CALCTL, 24'h0, OWN_CSEL, 31);
        cmp_bit(cal_en, 1'b1, "short frame");
        wr(REG_CALCTL, 24'h000002);
        cmp_bit(dbl, 1'b0, "fresh frame");
        cmp_bit(oe, 1'b1, "addressed");
        // calibration: busy seen in the next reply, result after
        wr(REG_PTR, 24'h8);
        wr(REG_CALSTB, 24'h0);
        cmp_word(rep, {24'h0, REG_STATUS, OWN_CSEL}, "old pointer");
        wr(REG_PTR, 24'h8);
        cmp_word(rep, {24'h10, REG_STATUS, OWN_CSEL}, "busy");
        wr(REG_PTR, 24'h8);
        cmp_word(rep, {24'h0A, REG_STATUS, OWN_CSEL}, "done");
        cmp_word({28'h0, fine}, 32'hA, "copied");
        wr(REG_FINEBW, 24'h3);
        cmp_word({28'h0, fine}, 32'h3, "override");
        // fuses: strobe refused while write mode is off
        wr(REG_FUSEIDX, 24'h1);
        wr(REG_FUSESTB, 24'h0);
        cmp_bit(fpulse, 1'b0, "fuse write off");
        wr(REG_FUSEWEN, 24'h1);
        wr(REG_FUSESTB, 24'h5A);
        cmp_bit(fpulse, 1'b1, "fuse pulse");
        repeat (20) @(negedge clk);
        cmp_bit(fpulse, 1'b0, "pulse over");
        wr(REG_FUSEIDX, 24'hD);
        wr(REG_FUSESTB, 24'h0);
        repeat (20) @(negedge clk);
        wr(REG_FUSEWEN, 24'h0);
        cmp_word({28'h0, fine}, 32'h2, "fuse code used");
        rd(REG_FUSEVAL, 24'h002002);
        // soft reset needs the one and then the zero
        wr(REG_PTR, 24'h20);
        cmp_bit(cal_en, 1'b1, "half soft reset");
        wr(REG_PTR, 24'h0);
        cmp_bit(cal_en, 1'b0, "soft reset");
        rd(REG_CALCTL, 24'h0);
        rd(REG_FUSEVAL, 24'h002002);
        cmp_word({28'h0, fine}, 32'h2, "fuse kept");
        // power cycle mid-run: quiet outputs, settle, defaults again
        arst_n = 1'b0;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        cmp_word({23'h0, fine, dbl, cal_en, fpulse, oe, ready}, 32'h0,
                 "second reset");
        repeat (40) if (ready !== 1'b1) @(negedge clk);
        cmp_bit(ready, 1'b1, "ready again");
        rd(REG_MEASADJ, 24'h0);
        results();
    end
endmodule : tb_filter_control_serial_port
